// file: rtl/olcv_top.sv
`timescale 1ns/1ps
`include "olcv_cfg.svh"

// ==========================================================================
// Lock, checksum and register access integrity
// ==========================================================================
// What this block does
// - Burning a block also fills its lock, identifier and checksum register.
// - Lock register: lock flag bit 7, identifier bits 6:4, checksum bits 3:0.
// - Lock flag 0 before programming, 1 after; checksum 0000 then computed.
// - Identifiers after programming: mirror 000, A-D 001-100, E 101, F 110.
// - Reads of reserved registers or bits still return a valid response.
// - Writes to reserved registers execute and get a valid response.
// - Reads outside the map answer validly with zero data.
// - Writes outside the map change nothing and answer with zero data.
// - Writes to read-only registers are dropped; answer shows current contents.
// - Factory blocks are checked by a 4-bit checksum per 16 bytes.
// - User regions zero and one get the same per-block 4-bit checksum check.
// - Checksum uses x^4+x^3+1 with all-zero seed.
// - Checksum takes bytes in ascending address, each byte MSB first.
// - The OTP mirror copy is checked against the mirror lock register checksum.
// - Before init done, OTP-loaded mirror values may be overwritten.
// - After init done, a running checksum covers the R/W window and mirror registers.
// - User registers are writable only before init done in allowed modes.
module olcv_top
  import olcv_pkg::*;
#(
  parameter int BLK_BYTES = `OLCV_BLOCK_BYTES
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic CMD_VALID_I,
  input wire logic CMD_WRITE_I,
  input wire logic [7:0] CMD_ADDR_I,
  input wire logic [7:0] CMD_WDATA_I,
  input wire logic PROTO_ALLOW_I,
  input wire logic BURN_START_I,
  input wire logic [2:0] BURN_BLOCK_I,
  input wire logic OTP_LOAD_I,
  input wire logic [7:0] OTP_LOAD_ADDR_I,
  input wire logic [7:0] OTP_LOAD_DATA_I,
  input wire logic OTP_CHECK_I,
  input wire logic [2:0] OTP_CHECK_BLOCK_I,
  output logic RSP_VALID_O,
  output logic [7:0] RSP_DATA_O,
  output logic RD_REQ_O,
  output logic [7:0] RD_ADDR_O,
  output logic BURN_DONE_O,
  output logic INIT_DONE_O,
  output logic INTEGRITY_ERR_O,
  output logic [3:0] RUN_CRC_O
);

  // Storage for the R/W window and the mirrored user region.
  logic [7:0] rw_mem_r [`OLCV_ADDR_RW_LO:`OLCV_ADDR_RW_HI];
  logic [7:0] mir_mem_r [`OLCV_ADDR_MIRROR_LO:`OLCV_ADDR_MIRROR_HI];
  logic [7:0] lck_r [0:6];
  logic [7:0] devlock_r;
  logic init_done_flag_r;
  logic err_r;
  olcv_state_t state_r;
  olcv_blk_t blk_r;
  logic chk_mode_r;
  logic [3:0] crc_r;
  logic [3:0] run_crc_r;
  logic [7:0] scan_addr_r;
  logic [4:0] byte_cnt_r;
  logic rd_pend_r;
  logic [7:0] rd_data_nxt;

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  // One byte, MSB first, through the x^4+x^3+1 shift register.
  function automatic logic [3:0] crc_byte(input logic [3:0] c, input logic [7:0] d);
    logic [3:0] x;
    x = c;
    for (int i = 7; i >= 0; i--) begin
      x = ({x[2:0], 1'b0}) ^ ((x[3] ^ d[i]) ? `OLCV_CRC_POLY : 4'h0);
    end
    return x;
  endfunction

  function automatic logic is_lck(input logic [7:0] a);
    return (a == `OLCV_ADDR_MIRROR_LCK) || (a[3:0] == 4'hF && a[7:4] >= 4'hA);
  endfunction

  function automatic logic [2:0] lck_idx(input logic [7:0] a);
    return (a == `OLCV_ADDR_MIRROR_LCK) ? 3'h0 : 3'(a[7:4] - 4'h9);
  endfunction

  function automatic logic is_rw(input logic [7:0] a);
    return a >= `OLCV_ADDR_RW_LO && a <= `OLCV_ADDR_RW_HI;
  endfunction

  function automatic logic is_mir(input logic [7:0] a);
    return a >= `OLCV_ADDR_MIRROR_LO && a <= `OLCV_ADDR_MIRROR_HI;
  endfunction

  function automatic logic [7:0] blk_base(input olcv_blk_t b);
    return (b == OLCV_BLK_MIRROR) ? `OLCV_ADDR_MIRROR_LO : {4'(b) + 4'h9, 4'h0};
  endfunction

  // Identifier field written into a lock register once its block is burned.
  function automatic logic [2:0] blk_ident(input olcv_blk_t b);
    logic [2:0] id;
    unique case (b)
      OLCV_BLK_MIRROR: id = `OLCV_ID_MIRROR;
      OLCV_BLK_A: id = `OLCV_ID_A;
      OLCV_BLK_B: id = `OLCV_ID_B;
      OLCV_BLK_C: id = `OLCV_ID_C;
      OLCV_BLK_D: id = `OLCV_ID_D;
      OLCV_BLK_E: id = `OLCV_ID_E;
      OLCV_BLK_F: id = `OLCV_ID_F;
      default: id = `OLCV_ID_MIRROR;
    endcase
    return id;
  endfunction

  function automatic logic [7:0] reg_read(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (is_lck(a)) v = lck_r[lck_idx(a)];
    else if (is_rw(a)) v = rw_mem_r[a];
    else if (is_mir(a)) v = mir_mem_r[a];
    else if (a == `OLCV_ADDR_DEVLOCK) v = devlock_r;
    else if (a == `OLCV_ADDR_INIT) v = {7'h00, init_done_flag_r};
    else if (a == `OLCV_ADDR_STATUS) v = {6'h00, state_r != OLCV_IDLE, err_r};
    return v;
  endfunction

  wire logic user_wr_ok = !init_done_flag_r && PROTO_ALLOW_I;
  wire logic cmd_wr = CMD_VALID_I && CMD_WRITE_I;

  // ==========================================================================
  // Register writes and OTP load
  // ==========================================================================
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = `OLCV_ADDR_RW_LO; i <= `OLCV_ADDR_RW_HI; i++) rw_mem_r[i] <= 8'h00;
      for (int i = `OLCV_ADDR_MIRROR_LO; i <= `OLCV_ADDR_MIRROR_HI; i++) mir_mem_r[i] <= 8'h00;
      devlock_r <= 8'h00;
    end else begin
      if (OTP_LOAD_I && is_mir(OTP_LOAD_ADDR_I) && !init_done_flag_r) begin
        mir_mem_r[OTP_LOAD_ADDR_I] <= OTP_LOAD_DATA_I;
      end
      if (cmd_wr && user_wr_ok) begin
        // Writes land even in reserved positions; read-only and unmapped are dropped.
        if (is_rw(CMD_ADDR_I)) rw_mem_r[CMD_ADDR_I] <= CMD_WDATA_I;
        else if (is_mir(CMD_ADDR_I)) mir_mem_r[CMD_ADDR_I] <= CMD_WDATA_I;
        else if (CMD_ADDR_I == `OLCV_ADDR_DEVLOCK) devlock_r <= CMD_WDATA_I;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      init_done_flag_r <= 1'b0;
    end else if (cmd_wr && CMD_ADDR_I == `OLCV_ADDR_INIT && CMD_WDATA_I[0]) begin
      init_done_flag_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Command answer
  // ==========================================================================
  // Read-only, unmapped and blocked writes answer one cycle later, like reads.
  always_comb begin
    rd_data_nxt = reg_read(CMD_ADDR_I);
    if (cmd_wr && user_wr_ok && (is_rw(CMD_ADDR_I) || is_mir(CMD_ADDR_I)
        || CMD_ADDR_I == `OLCV_ADDR_DEVLOCK)) begin
      rd_data_nxt = CMD_WDATA_I;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RSP_VALID_O <= 1'b0;
      RSP_DATA_O <= 8'h00;
    end else begin
      // Every command gets one answer, so the master never waits on a refusal.
      RSP_VALID_O <= CMD_VALID_I;
      if (CMD_VALID_I) RSP_DATA_O <= rd_data_nxt;
    end
  end

  // ==========================================================================
  // Block checksum engine
  // ==========================================================================
  wire logic [7:0] scan_byte = rd_pend_r ? OTP_LOAD_DATA_I : 8'h00;
  // Burn wins when both starts arrive in one cycle.
  olcv_blk_t start_blk;
  assign start_blk = olcv_blk_t'(BURN_START_I ? BURN_BLOCK_I : OTP_CHECK_BLOCK_I);

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_r <= OLCV_IDLE;
      blk_r <= OLCV_BLK_MIRROR;
      chk_mode_r <= 1'b0;
      crc_r <= `OLCV_CRC_SEED;
      scan_addr_r <= 8'h00;
      byte_cnt_r <= 5'h00;
      rd_pend_r <= 1'b0;
      RD_REQ_O <= 1'b0;
      RD_ADDR_O <= 8'h00;
      BURN_DONE_O <= 1'b0;
    end else begin
      BURN_DONE_O <= 1'b0;
      RD_REQ_O <= 1'b0;
      rd_pend_r <= RD_REQ_O;
      unique case (state_r)
        OLCV_IDLE: begin
          // Starts are only looked at here, so one that arrives mid-scan is dropped.
          if (BURN_START_I || OTP_CHECK_I) begin
            blk_r <= start_blk;
            chk_mode_r <= !BURN_START_I;
            crc_r <= `OLCV_CRC_SEED;
            scan_addr_r <= blk_base(start_blk);
            byte_cnt_r <= 5'h00;
            state_r <= OLCV_BURN;
          end
        end
        OLCV_BURN: begin
          // Issue one read of the block byte, then absorb it two cycles later.
          RD_REQ_O <= 1'b1;
          RD_ADDR_O <= scan_addr_r;
          state_r <= OLCV_SCAN;
        end
        OLCV_SCAN: begin
          if (rd_pend_r) begin
            crc_r <= crc_byte(crc_r, scan_byte);
            scan_addr_r <= scan_addr_r + 8'h01;
            byte_cnt_r <= byte_cnt_r + 5'h01;
            if (byte_cnt_r == 5'(BLK_BYTES - 1)) begin
              state_r <= OLCV_IDLE;
              BURN_DONE_O <= !chk_mode_r;
            end else begin
              state_r <= OLCV_BURN;
            end
          end
        end
        default: state_r <= OLCV_IDLE;
      endcase
    end
  end

  wire logic [3:0] final_crc = crc_byte(crc_r, scan_byte);
  wire logic scan_last = state_r == OLCV_SCAN && rd_pend_r
      && byte_cnt_r == 5'(BLK_BYTES - 1);
  // The block code doubles as the slot number of its lock register.
  wire logic [2:0] blk_idx = 3'(blk_r);

  // One slot per block; a slot changes only on the last byte of its own burn.
  for (genvar g = 0; g < 7; g++) begin : g_lck
    wire logic slot_wr = scan_last && !chk_mode_r && blk_idx == 3'(g);

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
        lck_r[g] <= 8'h00;
      end else if (slot_wr) begin
        lck_r[g] <= {1'b1, blk_ident(blk_r), final_crc};
      end
    end
  end

  // ==========================================================================
  // Block check verdict
  // ==========================================================================
  // An unburned block is compared against its zero field, so checking one
  // reports a mismatch unless its data happens to check to zero.
  logic blk_bad_r;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      blk_bad_r <= 1'b0;
    end else begin
      blk_bad_r <= scan_last && chk_mode_r && final_crc != lck_r[blk_idx][3:0];
    end
  end

  // ==========================================================================
  // Running checksum over R/W window and mirror region, and error flag
  // ==========================================================================
  logic [7:0] run_addr_r;
  logic [3:0] run_acc_r;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      run_addr_r <= `OLCV_ADDR_RW_LO;
      run_acc_r <= `OLCV_CRC_SEED;
      run_crc_r <= `OLCV_CRC_SEED;
    end else if (init_done_flag_r) begin
      run_acc_r <= crc_byte(run_acc_r, is_rw(run_addr_r) ? rw_mem_r[run_addr_r]
                                                         : mir_mem_r[run_addr_r]);
      if (run_addr_r == `OLCV_ADDR_MIRROR_HI) begin
        run_crc_r <= crc_byte(run_acc_r, mir_mem_r[run_addr_r]);
        run_acc_r <= `OLCV_CRC_SEED;
        run_addr_r <= `OLCV_ADDR_RW_LO;
      end else if (run_addr_r == `OLCV_ADDR_RW_HI) begin
        run_addr_r <= `OLCV_ADDR_MIRROR_LO;
      end else begin
        run_addr_r <= run_addr_r + 8'h01;
      end
    end
  end

  // First completed pass after init done sets the reference value.
  logic run_ref_vld_r;
  logic [3:0] run_ref_r;
  logic run_wrap_r;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      run_wrap_r <= 1'b0;
      run_ref_vld_r <= 1'b0;
      run_ref_r <= 4'h0;
      err_r <= 1'b0;
    end else begin
      run_wrap_r <= init_done_flag_r && run_addr_r == `OLCV_ADDR_MIRROR_HI;
      if (run_wrap_r && !run_ref_vld_r) begin
        run_ref_vld_r <= 1'b1;
        run_ref_r <= run_crc_r;
      end
      if (blk_bad_r) err_r <= 1'b1;
      if (run_wrap_r && run_ref_vld_r && run_crc_r != run_ref_r) err_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      INIT_DONE_O <= 1'b0;
      INTEGRITY_ERR_O <= 1'b0;
      RUN_CRC_O <= 4'h0;
    end else begin
      INIT_DONE_O <= init_done_flag_r;
      INTEGRITY_ERR_O <= err_r;
      RUN_CRC_O <= run_crc_r;
    end
  end

endmodule // olcv_top

// file: inc/olcv_cfg.svh
`ifndef OLCV_CFG_SVH
`define OLCV_CFG_SVH
// ==========================================================================
// Register offsets
// ==========================================================================
`define OLCV_ADDR_MIRROR_LCK 8'h5F
`define OLCV_ADDR_BLK_A_LCK 8'hAF
`define OLCV_ADDR_BLK_B_LCK 8'hBF
`define OLCV_ADDR_BLK_C_LCK 8'hCF
`define OLCV_ADDR_BLK_D_LCK 8'hDF
`define OLCV_ADDR_BLK_E_LCK 8'hEF
`define OLCV_ADDR_BLK_F_LCK 8'hFF
`define OLCV_ADDR_DEVLOCK 8'h10
`define OLCV_ADDR_INIT 8'h12
`define OLCV_ADDR_STATUS 8'h13
`define OLCV_ADDR_RW_LO 8'h14
`define OLCV_ADDR_RW_HI 8'h1F
`define OLCV_ADDR_MIRROR_LO 8'h50
`define OLCV_ADDR_MIRROR_HI 8'h5E
// ==========================================================================
// Field positions and values
// ==========================================================================
`define OLCV_LOCK_BIT 7
`define OLCV_ID_HI 6
`define OLCV_ID_LO 4
`define OLCV_CRC_HI 3
`define OLCV_CRC_LO 0
`define OLCV_CRC_SEED 4'h0
`define OLCV_CRC_POLY 4'h9
`define OLCV_ID_MIRROR 3'h0
`define OLCV_ID_A 3'h1
`define OLCV_ID_B 3'h2
`define OLCV_ID_C 3'h3
`define OLCV_ID_D 3'h4
`define OLCV_ID_E 3'h5
`define OLCV_ID_F 3'h6
`define OLCV_BLOCK_BYTES 16
`define OLCV_STAT_ERR_BIT 0
`define OLCV_STAT_BUSY_BIT 1
`endif

// file: inc/olcv_pkg.sv
package olcv_pkg;
  typedef enum logic [1:0] {
    OLCV_IDLE = 2'b00,
    OLCV_BURN = 2'b01,
    OLCV_SCAN = 2'b10
  } olcv_state_t;
  typedef enum logic [2:0] {
    OLCV_BLK_MIRROR = 3'b000,
    OLCV_BLK_A = 3'b001,
    OLCV_BLK_B = 3'b010,
    OLCV_BLK_C = 3'b011,
    OLCV_BLK_D = 3'b100,
    OLCV_BLK_E = 3'b101,
    OLCV_BLK_F = 3'b110
  } olcv_blk_t;
endpackage

// file: verif/olcv_monitor.sv
`timescale 1ns/1ps
module olcv_monitor (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic CMD_VALID_I,
  input wire logic CMD_WRITE_I,
  input wire logic [7:0] CMD_ADDR_I,
  input wire logic [7:0] CMD_WDATA_I,
  input wire logic PROTO_ALLOW_I,
  input wire logic RSP_VALID_O,
  input wire logic [7:0] RSP_DATA_O,
  input wire logic RD_REQ_O,
  input wire logic [7:0] RD_ADDR_O,
  input wire logic BURN_DONE_O,
  input wire logic INIT_DONE_O,
  input wire logic INTEGRITY_ERR_O,
  input wire logic [3:0] RUN_CRC_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  // ==========================================================================
  // Checks
  // ==========================================================================
  rsp_follows_a: assert property (CMD_VALID_I |=> RSP_VALID_O)
    else $error("command not answered");
  rsp_cause_a: assert property (RSP_VALID_O |-> $past(CMD_VALID_I))
    else $error("answer without command");
  unmapped_zero_a: assert property (CMD_VALID_I && CMD_ADDR_I inside {[8'h20:8'h4F]}
    |=> RSP_DATA_O == 8'h00) else $error("unmapped answer not zero");
  rw_echo_a: assert property (CMD_VALID_I && CMD_WRITE_I && CMD_ADDR_I == 8'h14
    && PROTO_ALLOW_I && !INIT_DONE_O |=> RSP_DATA_O == $past(CMD_WDATA_I))
    else $error("write answer wrong");
  err_sticky_a: assert property (INTEGRITY_ERR_O |=> INTEGRITY_ERR_O)
    else $error("error flag cleared");
  init_sticky_a: assert property (INIT_DONE_O |=> INIT_DONE_O)
    else $error("init done cleared");
  crc_idle_a: assert property (!INIT_DONE_O |-> RUN_CRC_O == 4'h0)
    else $error("running checksum before init");
  rd_spacing_a: assert property (RD_REQ_O |=> !RD_REQ_O [*2])
    else $error("array reads too close");
  rd_ascend_a: assert property (RD_REQ_O ##3 RD_REQ_O |-> RD_ADDR_O == $past(RD_ADDR_O, 3) + 8'h01)
    else $error("array reads not ascending");
  burn_bound_a: assert property (RD_REQ_O && RD_ADDR_O[3:0] == 4'hF |=> !RD_REQ_O [*3])
    else $error("block scan overran");
endmodule // olcv_monitor
bind olcv_top olcv_monitor mon (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CMD_VALID_I(CMD_VALID_I),
  .CMD_WRITE_I(CMD_WRITE_I), .CMD_ADDR_I(CMD_ADDR_I), .CMD_WDATA_I(CMD_WDATA_I),
  .PROTO_ALLOW_I(PROTO_ALLOW_I), .RSP_VALID_O(RSP_VALID_O), .RSP_DATA_O(RSP_DATA_O),
  .RD_REQ_O(RD_REQ_O), .RD_ADDR_O(RD_ADDR_O), .BURN_DONE_O(BURN_DONE_O),
  .INIT_DONE_O(INIT_DONE_O), .INTEGRITY_ERR_O(INTEGRITY_ERR_O), .RUN_CRC_O(RUN_CRC_O));

// file: verif/olcv_otp_model.sv
`timescale 1ns/1ps
module olcv_otp_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic rd_req_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic corrupt_i,
  output logic [7:0] data_o
);
  logic [1:0] hold_r;
  // Array byte is held three edges, then toggles so a late sample is caught.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_o <= 8'h00;
      hold_r <= 2'h0;
    end else if (rd_req_i) begin
      data_o <= (rd_addr_i ^ 8'hA5) ^ {7'h00, corrupt_i};
      hold_r <= 2'h3;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule // olcv_otp_model

// file: verif/otp_lock_crc_verify_tb.sv
`timescale 1ns/1ps
module otp_lock_crc_verify_tb;
  logic clk = 0, rst_b = 0, cv = 0, cw = 0, proto = 1, bs = 0, ld = 0, ck = 0, bad = 0;
  logic [7:0] ca = 0, cd = 0, la = 0, lv = 0, md, d, rd_a;
  logic [2:0] bb = 0, cb = 0;
  logic rsp_v, rd_q, bdone, idone, ierr;
  logic [7:0] rsp_d;
  logic [3:0] rcrc;
  logic [7:0] shadow [0:26];
  int n_errors = 0, check_count = 0, cyc = 0;
  initial begin
    forever #20 clk = ~clk;
  end
  olcv_top dut (.CLK_I(clk), .RST_B_I(rst_b), .CMD_VALID_I(cv), .CMD_WRITE_I(cw),
    .CMD_ADDR_I(ca), .CMD_WDATA_I(cd), .PROTO_ALLOW_I(proto), .BURN_START_I(bs),
    .BURN_BLOCK_I(bb), .OTP_LOAD_I(ld), .OTP_LOAD_ADDR_I(la), .OTP_LOAD_DATA_I(ld ? lv : md),
    .OTP_CHECK_I(ck), .OTP_CHECK_BLOCK_I(cb), .RSP_VALID_O(rsp_v), .RSP_DATA_O(rsp_d),
    .RD_REQ_O(rd_q), .RD_ADDR_O(rd_a), .BURN_DONE_O(bdone), .INIT_DONE_O(idone),
    .INTEGRITY_ERR_O(ierr), .RUN_CRC_O(rcrc));
  olcv_otp_model otp (.clk_i(clk), .rst_b_i(rst_b), .rd_req_i(rd_q), .rd_addr_i(rd_a),
    .corrupt_i(bad), .data_o(md));
  function automatic logic [7:0] base(input logic [2:0] k);
    return (k == 3'h0) ? 8'h50 : 8'h90 + {1'b0, k, 4'h0};
  endfunction
  // Serial checksum over one block, bytes ascending, each byte MSB first.
  function automatic logic [3:0] crc_blk(input logic [7:0] b0);
    logic [3:0] c;
    logic [7:0] b;
    c = 4'h0;
    for (int i = 0; i < 16; i++) begin
      b = (b0 + i[7:0]) ^ 8'hA5;
      for (int j = 7; j >= 0; j--) c = {c[2:0], 1'b0} ^ ((c[3] ^ b[j]) ? 4'h9 : 4'h0);
    end
    return c;
  endfunction
  // Running checksum over the R/W window then the mirror region, ascending.
  function automatic logic [3:0] run_exp();
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 27; i++) begin
      for (int j = 7; j >= 0; j--) c = {c[2:0], 1'b0} ^ ((c[3] ^ shadow[i][j]) ? 4'h9 : 4'h0);
    end
    return c;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] v, input logic [7:0] e);
    @(negedge clk);
    {cv, cw, ca, cd} = {1'b1, w, a, v};
    @(negedge clk);
    cv = 0;
    // The answer stands one cycle, so it is looked at half a cycle after the taking edge.
    chk({7'h00, rsp_v}, 8'h01);
    chk(rsp_d, e);
  endtask
  task automatic run(input logic burn, input logic [2:0] k);
    @(negedge clk);
    {bs, bb, ck, cb} = {burn, k, !burn, k};
    @(negedge clk);
    {bs, ck} = 2'b00;
    for (int i = 0; i < 120 && !(burn && bdone === 1'b1); i++) begin
      @(posedge clk);
      #1;
    end
    if (burn) chk({7'h00, bdone}, 8'h01);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    foreach (shadow[i]) shadow[i] = 8'h00;
    void'($urandom(55));
    repeat (8) @(negedge clk);
    rst_b = 1;
    for (int k = 0; k < 7; k++) cmd(0, base(k[2:0]) | 8'h0F, 8'h00, 8'h00);
    $display("test unburned done");
    for (int k = 0; k < 7; k++) begin
      run(1, k[2:0]);
      cmd(0, base(k[2:0]) | 8'h0F, 8'h00, {1'b1, k[2:0], crc_blk(base(k[2:0]))});
    end
    $display("test burn done");
    cmd(1, 8'hAF, 8'($urandom), {4'h9, crc_blk(8'hA0)});
    cmd(0, 8'h30, 8'h00, 8'h00);
    cmd(1, 8'h31, 8'($urandom), 8'h00);
    cmd(0, 8'h31, 8'h00, 8'h00);
    $display("test refused done");
    repeat (4) begin
      d = 8'($urandom);
      la = 8'h14 + 8'($urandom % 12);
      cmd(1, la, d, d);
      shadow[la - 8'h14] = d;
      cmd(0, la, 8'h00, d);
    end
    cmd(1, 8'h14, 8'h5A, 8'h5A);
    shadow[0] = 8'h5A;
    proto = 0;
    cmd(1, 8'h14, 8'hA5, 8'h5A);
    proto = 1;
    @(negedge clk);
    {ld, la, lv} = {1'b1, 8'h50, 8'h3C};
    @(negedge clk);
    ld = 0;
    cmd(0, 8'h50, 8'h00, 8'h3C);
    cmd(1, 8'h50, 8'hC3, 8'hC3);
    shadow[12] = 8'hC3;
    $display("test writes done");
    run(0, 3'h1);
    run(0, 3'h0);
    chk({7'h00, ierr}, 8'h00);
    cmd(1, 8'h12, 8'h01, 8'h00);
    @(negedge clk);
    chk({7'h00, idone}, 8'h01);
    cmd(1, 8'h14, 8'h77, 8'h5A);
    repeat (300) @(posedge clk);
    #1;
    chk({7'h00, ierr}, 8'h00);
    chk({4'h0, rcrc}, {4'h0, run_exp()});
    bad = 1;
    run(0, 3'h2);
    chk({7'h00, ierr}, 8'h01);
    $display("test integrity done");
    test_done();
  end
endmodule // otp_lock_crc_verify_tb
